// ==== inc/crl_regs.svh ====
// Constants for the code ROM lock and scrambling block
`ifndef CRL_REGS_SVH
`define CRL_REGS_SVH
`define CRL_CODE_ADDR_W   13
`define CRL_CODE_BYTES    8192
`define CRL_ENC_IDX_W     6
`define CRL_ENC_BYTES     64
`define CRL_SIG_BYTES     4
`define CRL_SIG_IDX_W     2
`define CRL_ERASED_BYTE   8'hff
`define CRL_BLOCKED_BYTE  8'hff
`define CRL_SIG_LOC0      16'h0030
`define CRL_SIG_LOC1      16'h0031
`define CRL_SIG_LOC2      16'h0060
`define CRL_SIG_LOC3      16'h0061
`define CRL_SIG_VAL0      8'h11
`define CRL_SIG_VAL1      8'h22
`define CRL_SIG_VAL2      8'h33
`define CRL_SIG_VAL3      8'h44
`endif

// ==== inc/crl_pkg.sv ====
// Types for the code ROM lock and scrambling block
package crl_pkg;
    typedef enum logic [1:0] {
        CRL_LEVEL1 = 2'h0,
        CRL_LEVEL2 = 2'h1,
        CRL_LEVEL3 = 2'h3
    } crl_level_type;

    typedef struct packed {
        crl_level_type level;
        logic          ext_access_latched;
        logic [7:0]    verify_data;
        logic          verify_refused;
        logic [7:0]    fetch_data;
        logic          fetch_blocked;
    } crl_state_type;
endpackage

// ==== hw/crl_code_rom_lock.sv ====
// Code ROM with encryption array, signature bytes and lock levels
`timescale 1ns/1ns
`default_nettype none
`include "crl_regs.svh"

module crl_code_rom_lock #(
    parameter int  CODE_AW   = `CRL_CODE_ADDR_W,
    parameter int  ENC_AW    = `CRL_ENC_IDX_W,
    parameter logic [7:0] SIG_VAL0 = `CRL_SIG_VAL0, // Arbitrary value
    parameter logic [7:0] SIG_VAL1 = `CRL_SIG_VAL1, // Arbitrary value
    parameter logic [7:0] SIG_VAL2 = `CRL_SIG_VAL2, // Arbitrary value
    parameter logic [7:0] SIG_VAL3 = `CRL_SIG_VAL3  // Arbitrary value
) (
    input  wire logic                 sys_clk,
    input  wire logic                 rst,
    input  wire logic                 lock_bit_first,
    input  wire logic                 lock_bit_second,
    input  wire logic                 external_access_select,
    input  wire logic                 verify_en,
    input  wire logic                 signature_en,
    input  wire logic [15:0]          verify_addr,
    input  wire logic                 enc_write_en,
    input  wire logic [ENC_AW-1:0]    enc_write_addr,
    input  wire logic [7:0]           enc_write_data,
    input  wire logic                 code_write_en,
    input  wire logic [CODE_AW-1:0]   code_write_addr,
    input  wire logic [7:0]           code_write_data,
    input  wire logic                 code_table_read_instruction,
    input  wire logic                 fetch_from_external,
    input  wire logic [CODE_AW-1:0]   fetch_addr,
    output logic [7:0]                verify_data,
    output logic                      verify_refused,
    output logic [7:0]                fetch_data,
    output logic                      fetch_blocked,
    output logic                      ext_access_latched,
    output logic [1:0]                security_level
);
    // ==========================================================
    // Arrays
    // ==========================================================
    // Depths follow the address widths
    localparam int CODE_DEPTH = 1 << CODE_AW;
    localparam int ENC_DEPTH  = 1 << ENC_AW;

    // Separate arrays, each with its own address
    logic [7:0] code_mem [0:CODE_DEPTH-1];
    logic [7:0] enc_mem  [0:ENC_DEPTH-1];

    crl_pkg::crl_state_type state_reg;
    crl_pkg::crl_state_type state_next;

    // ==========================================================
    // Helpers
    // ==========================================================
    // Signature bytes sit at fixed addresses; any other address reads erased
    function automatic logic [7:0] sig_lookup(input logic [15:0] a);
        case (a)
            `CRL_SIG_LOC0: sig_lookup = SIG_VAL0;
            `CRL_SIG_LOC1: sig_lookup = SIG_VAL1;
            `CRL_SIG_LOC2: sig_lookup = SIG_VAL2;
            `CRL_SIG_LOC3: sig_lookup = SIG_VAL3;
            default:       sig_lookup = `CRL_ERASED_BYTE;
        endcase
    endfunction

    function automatic crl_pkg::crl_level_type decode_level(input logic lb1, input logic lb2);
        // Inputs are high when the lock bit is programmed
        if (lb2) begin
            decode_level = crl_pkg::CRL_LEVEL3;
        end else if (lb1) begin
            decode_level = crl_pkg::CRL_LEVEL2;
        end else begin
            decode_level = crl_pkg::CRL_LEVEL1;
        end
    endfunction

    // An erased key byte is all ones, so XNOR hands the code byte back
    function automatic logic [7:0] scramble(input logic [7:0] code, input logic [7:0] key);
        scramble = ~(code ^ key);
    endfunction

    // Fetches from inside are never stopped, whatever the level
    function automatic logic table_read_stopped(
        input logic                   table_read,
        input logic                   from_external,
        input crl_pkg::crl_level_type level
    );
        table_read_stopped = table_read && from_external
                             && (level != crl_pkg::CRL_LEVEL1);
    endfunction

    // ==========================================================
    // Erased start
    // ==========================================================
    // Arrays start erased so unscrambled output is the default
    initial begin
        for (int i = 0; i < ENC_DEPTH; i++) begin
            enc_mem[i] = `CRL_ERASED_BYTE;
        end
        for (int i = 0; i < CODE_DEPTH; i++) begin
            code_mem[i] = `CRL_ERASED_BYTE;
        end
    end

    // ==========================================================
    // Mask and key load port
    // ==========================================================
    always_ff @(posedge sys_clk) begin
        if (enc_write_en) begin
            enc_mem[enc_write_addr] <= enc_write_data;
        end
        if (code_write_en) begin
            code_mem[code_write_addr] <= code_write_data;
        end
    end

    // ==========================================================
    // Read paths
    // ==========================================================
    logic [7:0]             code_byte;
    logic [7:0]             key_byte;
    logic [7:0]             sig_byte;
    logic [7:0]             verify_byte;
    logic [7:0]             plain_fetch_byte;
    crl_pkg::crl_level_type reset_level;
    logic                   reset_pin;
    logic                   verify_open;
    logic                   fetch_stop;

    assign code_byte        = code_mem[verify_addr[CODE_AW-1:0]];
    assign key_byte         = enc_mem[verify_addr[ENC_AW-1:0]];
    assign sig_byte         = sig_lookup(verify_addr);
    // Limitation: long blank code stretches read back as the key itself
    assign verify_byte      = scramble(code_byte, key_byte);
    assign plain_fetch_byte = code_mem[fetch_addr];
    // Lock bits and pin count only while reset is high
    assign reset_level      = decode_level(lock_bit_first, lock_bit_second);
    assign reset_pin        = external_access_select;
    // Locks act on the held level, so later lock bit changes do nothing
    assign verify_open      = state_reg.level != crl_pkg::CRL_LEVEL3;
    assign fetch_stop       = table_read_stopped(code_table_read_instruction,
                                                 fetch_from_external,
                                                 state_reg.level);

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb begin
        state_next                = state_reg;
        state_next.verify_refused = 1'h0;
        case ({signature_en, verify_en})
            2'h2, 2'h3: begin
                // Signature wins over verify and is open at every level
                state_next.verify_data = sig_byte;
            end
            2'h1: begin
                if (verify_open) begin
                    // Scrambled at levels 1 and 2, including level 1
                    state_next.verify_data = verify_byte;
                end else begin
                    state_next.verify_data    = `CRL_BLOCKED_BYTE;
                    state_next.verify_refused = 1'h1;
                end
            end
            default: begin
                // Last byte stays on the data lines between reads
                state_next.verify_data = state_reg.verify_data;
            end
        endcase
        if (fetch_stop) begin
            state_next.fetch_data    = `CRL_BLOCKED_BYTE;
            state_next.fetch_blocked = 1'h1;
        end else begin
            // Plain bytes at level 1 and for every internal fetch
            state_next.fetch_data    = plain_fetch_byte;
            state_next.fetch_blocked = 1'h0;
        end
    end

    // ==========================================================
    // Registers
    // ==========================================================
    // Pin is sampled during reset so it is caught on release
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_reg.level              <= reset_level;
            state_reg.ext_access_latched <= reset_pin;
            state_reg.verify_data        <= `CRL_ERASED_BYTE;
            state_reg.verify_refused     <= 1'h0;
            state_reg.fetch_data         <= '0;
            state_reg.fetch_blocked      <= 1'h0;
        end else begin
            state_reg <= state_next;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    // Every output is a register bit, so no glitch reaches the pins
    assign verify_data        = state_reg.verify_data;
    assign verify_refused     = state_reg.verify_refused;
    assign fetch_data         = state_reg.fetch_data;
    assign fetch_blocked      = state_reg.fetch_blocked;
    assign ext_access_latched = state_reg.ext_access_latched;
    assign security_level     = state_reg.level;
endmodule
`default_nettype wire

// ==== bench/crl_checker.sv ====
// Assertions on the code ROM lock block ports
`timescale 1ns/1ns
`default_nettype none
module crl_checker (
    input wire logic       sys_clk,
    input wire logic       rst,
    input wire logic       verify_en,
    input wire logic       signature_en,
    input wire logic       code_table_read_instruction,
    input wire logic       fetch_from_external,
    input wire logic [7:0] verify_data,
    input wire logic       verify_refused,
    input wire logic [7:0] fetch_data,
    input wire logic       fetch_blocked,
    input wire logic [1:0] security_level
);
    wire logic lvl1 = (security_level == 2'h0);
    wire logic lvl3 = (security_level == 2'h3);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence s_ver; verify_en && !signature_en; endsequence
    sequence s_tbl; code_table_read_instruction && fetch_from_external; endsequence
    property p_refuse; s_ver ##0 lvl3 |=> verify_refused && verify_data == 8'hff; endproperty
    a_refuse: assert property (p_refuse) else $error("verify not refused");
    property p_noref; s_ver ##0 !lvl3 |=> !verify_refused; endproperty
    a_noref: assert property (p_noref) else $error("verify wrongly refused");
    property p_sig; signature_en |=> !verify_refused; endproperty
    a_sig: assert property (p_sig) else $error("signature read refused");
    property p_block; s_tbl ##0 !lvl1 |=> fetch_blocked && fetch_data == 8'hff; endproperty
    a_block: assert property (p_block) else $error("table read not blocked");
    property p_open; s_tbl ##0 lvl1 |=> !fetch_blocked; endproperty
    a_open: assert property (p_open) else $error("table read blocked");
    property p_idle; !code_table_read_instruction |=> !fetch_blocked; endproperty
    a_idle: assert property (p_idle) else $error("block flag without read");
    property p_keep; $stable(security_level); endproperty
    a_keep: assert property (p_keep) else $error("level changed while running");
    property p_code; security_level != 2'h2; endproperty
    a_code: assert property (p_code) else $error("illegal level code");
endmodule
bind crl_code_rom_lock crl_checker i_chk (
    .sys_clk                     (sys_clk),
    .rst                         (rst),
    .verify_en                   (verify_en),
    .signature_en                (signature_en),
    .code_table_read_instruction (code_table_read_instruction),
    .fetch_from_external         (fetch_from_external),
    .verify_data                 (verify_data),
    .verify_refused              (verify_refused),
    .fetch_data                  (fetch_data),
    .fetch_blocked               (fetch_blocked),
    .security_level              (security_level)
);
`default_nettype wire

// ==== bench/crl_verifier.sv ====
// Model of an external programmer driving the verify pins
`timescale 1ns/1ns
`default_nettype none
module crl_verifier (
    input wire logic  sys_clk,
    input wire logic  req_ver,
    input wire logic  req_sig,
    input wire logic  [15:0] req_addr,
    output logic      verify_en,
    output logic      signature_en,
    output logic      [15:0] verify_addr
);
    logic [15:0] last_reg = 16'h0000;
    assign verify_en = req_ver;
    assign signature_en = req_sig;
    // Idle lines float; toggling pattern so stale addresses never look valid
    assign verify_addr = (req_ver || req_sig) ? req_addr : ~last_reg;
    always @(posedge sys_clk) last_reg <= verify_addr;
endmodule
`default_nettype wire

// ==== bench/code_rom_lock_encrypt_bench.sv ====
// Self-checking bench for the code ROM lock block
`timescale 1ns/1ns
`default_nettype none
`include "crl_regs.svh"
module code_rom_lock_encrypt_bench;
    logic sys_clk = 1'b0, rst = 1'b1, lock_bit_first, lock_bit_second, external_access_select;
    logic verify_en, signature_en, enc_write_en, code_write_en, req_ver, req_sig;
    logic code_table_read_instruction, fetch_from_external, verify_refused, fetch_blocked;
    logic ext_access_latched;
    logic [15:0] verify_addr, req_addr, rnd = 16'h0008;
    logic [15:0] sloc [4] = '{`CRL_SIG_LOC0, `CRL_SIG_LOC1, `CRL_SIG_LOC2, `CRL_SIG_LOC3};
    logic [7:0] sval [4] = '{`CRL_SIG_VAL0, `CRL_SIG_VAL1, `CRL_SIG_VAL2, `CRL_SIG_VAL3};
    logic [12:0] code_write_addr, fetch_addr;
    logic [7:0] enc_write_data, code_write_data, verify_data, fetch_data, code [8192], key [64];
    logic [5:0] enc_write_addr;
    logic [1:0] security_level;
    int mismatches = 0, cmp_count = 0, cyc = 0, lvl = 0, i, j;
    crl_code_rom_lock i_dut (
        .sys_clk                     (sys_clk),
        .rst                         (rst),
        .lock_bit_first              (lock_bit_first),
        .lock_bit_second             (lock_bit_second),
        .external_access_select      (external_access_select),
        .verify_en                   (verify_en),
        .signature_en                (signature_en),
        .verify_addr                 (verify_addr),
        .enc_write_en                (enc_write_en),
        .enc_write_addr              (enc_write_addr),
        .enc_write_data              (enc_write_data),
        .code_write_en               (code_write_en),
        .code_write_addr             (code_write_addr),
        .code_write_data             (code_write_data),
        .code_table_read_instruction (code_table_read_instruction),
        .fetch_from_external         (fetch_from_external),
        .fetch_addr                  (fetch_addr),
        .verify_data                 (verify_data),
        .verify_refused              (verify_refused),
        .fetch_data                  (fetch_data),
        .fetch_blocked               (fetch_blocked),
        .ext_access_latched          (ext_access_latched),
        .security_level              (security_level)
    );
    crl_verifier i_prog (
        .sys_clk      (sys_clk),
        .req_ver      (req_ver),
        .req_sig      (req_sig),
        .req_addr     (req_addr),
        .verify_en    (verify_en),
        .signature_en (signature_en),
        .verify_addr  (verify_addr)
    );
    initial forever #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) final_report(1);
    end
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        mismatches += int'(g !== e);
        if (g !== e) $display("MISMATCH %s exp %h got %h", n, e, g);
    endtask
    task automatic final_report(input int to);
        mismatches += to;
        if (mismatches == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic do_reset(input logic a, input logic b);
        rst = 1'b1;
        {lock_bit_first, lock_bit_second, external_access_select} = {a, b, a ^ ~b};
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        rst = 1'b0;
        lvl = b ? 3 : a ? 1 : 0;
        // Pin and lock bits move after reset; the held copies must not follow
        external_access_select = ~external_access_select;
        {lock_bit_first, lock_bit_second} = ~{a, b};
        cmp("level", 8'(lvl), {6'h00, security_level});
        cmp("pin_latch", {7'h00, a ^ ~b}, {7'h00, ext_access_latched});
    endtask
    task automatic load(input int n, input logic enc);
        for (i = 0; i < n; i++) begin
            rnd = lfsr(rnd);
            {enc_write_en, code_write_en, enc_write_addr, code_write_addr} = {enc, ~enc, 6'(i), 13'(i)};
            {enc_write_data, code_write_data} = rnd;
            if (enc) key[i] = rnd[15:8];
            else code[i] = rnd[7:0];
            @(negedge sys_clk);
        end
        {enc_write_en, code_write_en} = 2'b00;
    endtask
    task automatic op_run(input int m, input logic [15:0] a, input logic [1:0] k);
        logic [7:0] e;
        if (m == 1) a = sloc[k];
        // Signature reads sometimes overlap verify, which they must win over
        {req_ver, req_sig, code_table_read_instruction} = {m == 0 || (m == 1 && k[0]), m == 1, m == 2};
        {fetch_from_external, req_addr, fetch_addr} = {a[15], a, a[12:0]};
        @(negedge sys_clk);
        e = (lvl == 3) ? 8'hff : ~(code[a[12:0]] ^ key[a[5:0]]);
        if (m == 0) cmp("verify_data", e, verify_data);
        if (m == 0) cmp("verify_refused", 8'(lvl == 3), {7'h00, verify_refused});
        if (m == 1) cmp("signature", sval[k], verify_data);
        e = (a[15] && lvl != 0) ? 8'hff : code[a[12:0]];
        if (m == 2) cmp("fetch_data", e, fetch_data);
        if (m == 2) cmp("fetch_blocked", 8'(a[15] && lvl != 0), {7'h00, fetch_blocked});
    endtask
    initial begin
        {req_ver, req_sig, req_addr, code_table_read_instruction, fetch_from_external} = '0;
        {enc_write_en, code_write_en, enc_write_addr, code_write_addr, fetch_addr} = '0;
        {enc_write_data, code_write_data} = '0;
        for (i = 0; i < 8192; i++) code[i] = 8'hff;
        for (i = 0; i < 64; i++) key[i] = 8'hff;
        do_reset(1'b0, 1'b0);
        load(128, 1'b0);
        for (j = 0; j < 128; j++) op_run(0, {j[2:0], 6'h00, j[6:0]}, 2'h0);
        load(64, 1'b1);
        for (j = 0; j < 4; j++) begin
            do_reset(j[0], j[1]);
            for (i = 0; i < 150; i++) begin
                rnd = lfsr(rnd);
                op_run(int'(rnd[9:8]) % 3, {rnd[15:13], 6'h00, rnd[6:0]}, rnd[11:10]);
            end
            cmp("pin_hold", {7'h00, j[0] ^ ~j[1]}, {7'h00, ext_access_latched});
            cmp("level_hold", 8'(lvl), {6'h00, security_level});
        end
        final_report(0);
    end
endmodule
`default_nettype wire
